// ===== core/gg_pkg.sv
// Shared constants and types for the gas-gauge host command port.
// Functional notes
// - Host sends address, then eight-bit command code.
// - Only word read, word write, block read.
// - Code 0x00 accepted, does nothing.
// - Capacity below threshold sets capacity alarm.
// - Average time below threshold sets time alarm.
// - Thresholds are writable, used at once.
// - Time threshold loads from configuration after reset.
// - Mode word writable; capacity unit mAh only.
// - Mode bit 14 mutes charge current/voltage messages.
// - Both lines low over 2 s clears bit 14.
// - Mode bit 13 mutes all charger messages.
// - Configuration flag sets mode bit 13 at load.
// - Temperature word read-only, tenth kelvin, 0..5000.
// - Reset loads zeros, error margin 100, time threshold 10.
// - Device broadcasts charge words unless muted.
package gg_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CODE_VENDOR    = 8'h00;
  localparam logic [7:0] CODE_CAP_THR   = 8'h01;
  localparam logic [7:0] CODE_TIME_THR  = 8'h02;
  localparam logic [7:0] CODE_MODE      = 8'h03;
  localparam logic [7:0] CODE_TEMP      = 8'h08;
  localparam logic [7:0] CODE_VOLT      = 8'h09;
  localparam logic [7:0] CODE_CURR      = 8'h0a;
  localparam logic [7:0] CODE_AVG_CURR  = 8'h0b;
  localparam logic [7:0] CODE_ERR       = 8'h0c;
  localparam logic [7:0] CODE_PCT_FULL  = 8'h0d;
  localparam logic [7:0] CODE_PCT_DSGN  = 8'h0e;
  localparam logic [7:0] CODE_CAP_LEFT  = 8'h0f;
  localparam logic [7:0] CODE_FULL_CAP  = 8'h10;
  localparam logic [7:0] CODE_MIN_NOW   = 8'h11;
  localparam logic [7:0] CODE_MIN_AVG   = 8'h12;
  localparam logic [7:0] CODE_CHG_CURR  = 8'h14;
  localparam logic [7:0] CODE_CHG_VOLT  = 8'h15;
  localparam logic [7:0] CODE_STATUS    = 8'h16;
  localparam logic [7:0] CODE_CYCLES    = 8'h17;
  localparam logic [7:0] CODE_DSGN_CAP  = 8'h18;
  localparam logic [7:0] CODE_DSGN_VOLT = 8'h19;
  localparam logic [7:0] CODE_SPEC      = 8'h1a;
  localparam logic [7:0] CODE_DATE      = 8'h1b;
  localparam logic [7:0] CODE_SERIAL    = 8'h1c;
  localparam logic [7:0] CODE_MAKER_STR = 8'h20;
  localparam logic [7:0] CODE_PART_STR  = 8'h21;
  localparam logic [7:0] CODE_CHEM_STR  = 8'h22;
  localparam logic [7:0] CODE_DATA_STR  = 8'h23;
  localparam logic [7:0] CODE_CFG_FLAGS = 8'h2f;
  localparam logic [7:0] CODE_EDV_FIRST = 8'h3e;
  localparam logic [7:0] CODE_EDV_FINAL = 8'h3f;

  // ==========================================================
  // Field positions and masks
  localparam int unsigned MODE_CHG_OFF_BIT = 14;
  localparam int unsigned MODE_ALL_OFF_BIT = 13;
  localparam int unsigned CFG_QUIET_BIT    = 11; // Bit 3 of upper byte.
  localparam int unsigned STAT_CAP_BIT     = 9;
  localparam int unsigned STAT_TIME_BIT    = 8;
  localparam logic [15:0] MODE_WR_MASK     = 16'h7fff;
  localparam logic [15:0] STAT_ALARM_MASK  = 16'hdb00;
  localparam logic [15:0] STAT_OWN_MASK    = 16'h0300;

  // ==========================================================
  // Reset and fixed values
  localparam logic [15:0] RST_TIME_THR     = 16'h000a;
  localparam logic [15:0] RST_ERR_MARGIN   = 16'h0064;
  localparam logic [15:0] TEMP_MAX         = 16'h1388;
  localparam logic [15:0] RSVD_READ        = 16'h0000;
  localparam logic [7:0]  BLOCK_LEN        = 8'h02;
  localparam logic [7:0]  TX_PAD           = 8'hff;
  localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h55; // Arbitrary value.

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned REMOVE_TIME_MS  = 2000;
  localparam int unsigned REMOVE_CYCLES   = REMOVE_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned BCAST_TIME_MS   = 1000;
  localparam int unsigned BCAST_CYCLES    = BCAST_TIME_MS * CLK_MHZ * 1000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] voltage;
    logic [15:0] current;
    logic [15:0] avg_current;
    logic [15:0] error_margin;
    logic [15:0] pct_full;
    logic [15:0] pct_design;
    logic [15:0] capacity_left;
    logic [15:0] full_cap;
    logic [15:0] minutes_now;
    logic [15:0] minutes_avg;
    logic [15:0] chg_current;
    logic [15:0] chg_voltage;
    logic [15:0] status;
    logic [15:0] cycles;
  } gg_meas_s;

  typedef struct packed {
    logic [15:0] cap_thr;
    logic [15:0] time_thr;
    logic [15:0] design_cap;
    logic [15:0] design_volt;
    logic [15:0] spec_rev;
    logic [15:0] build_date;
    logic [15:0] serial;
    logic [15:0] maker_str;
    logic [15:0] part_str;
    logic [15:0] chem_str;
    logic [15:0] maker_data;
    logic [15:0] flag_word;
    logic [15:0] edv_first;
    logic [15:0] edv_final;
  } gg_cfg_s;

  typedef struct packed {
    logic        blk;
    logic [15:0] word;
  } gg_snap_s;

  typedef struct packed {
    logic [7:0]  code;
    logic [15:0] data;
  } gg_wr_s;

  typedef struct packed {
    logic        chg_valid;
    logic        alarm_valid;
    logic [15:0] chg_current;
    logic [15:0] chg_voltage;
    logic [15:0] alarm_status;
  } gg_bcast_s;

  localparam gg_meas_s MEAS_RST = '{error_margin: RST_ERR_MARGIN,
                                    default: 16'h0000};

endpackage : gg_pkg

// ===== core/gg_sync.sv
// Two-stage synchroniser for levels entering the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module gg_sync #(
  parameter int unsigned W       = 1,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // ==========================================================
  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= {W{RST_VAL}};
      q_o    <= {W{RST_VAL}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : gg_sync
`default_nettype wire

// ===== core/gg_cmd_port.sv
// Host command port of the gauge: two-wire slave, registers, broadcasts.
`timescale 1ns/1ps
`default_nettype none
module gg_cmd_port #(
  parameter int unsigned REMOVE_CYC = gg_pkg::REMOVE_CYCLES,
  parameter int unsigned BCAST_CYC  = gg_pkg::BCAST_CYCLES,
  parameter logic [6:0]  DEV_ADDR   = gg_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              link_clock_line_i,
  input  wire logic              link_data_line_i,
  output logic                   link_data_line_o,
  output logic                   link_data_line_oe_o,
  input  wire gg_pkg::gg_meas_s  meas_i,
  input  wire gg_pkg::gg_cfg_s   cfg_i,
  input  wire logic              cfg_load_i,
  output gg_pkg::gg_bcast_s      bcast_o,
  output logic [15:0]            mode_o,
  output logic [15:0]            status_o,
  output logic                   pack_removed_o
);
  import gg_pkg::*;

  // ==========================================================
  // Declarations, system clock domain
  logic [1:0]  pin_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic        in_frame_q;
  logic        link_run_q;
  logic [1:0]  tgl_s;
  logic [1:0]  tgl_seen_q;
  logic [7:0]  code_q;
  gg_snap_s    snap_q;
  gg_snap_s    rd_snap;
  logic [15:0] cap_thr_q;
  logic [15:0] time_thr_q;
  logic [15:0] mode_q;
  logic [15:0] mode_cfg;
  logic [15:0] mode_upd;
  logic [15:0] mode_d;
  logic [15:0] status_q;
  gg_meas_s    meas_q;
  gg_cfg_s     cfg_q;
  logic [31:0] lo_cnt_q;
  logic [31:0] bc_cnt_q;
  gg_bcast_s   bcast_q;

  // ==========================================================
  // Declarations, link clock domain
  logic        link_rst_n;
  logic [3:0]  bit_cnt_q;
  logic [2:0]  byte_idx_q;
  logic [7:0]  rx_sr_q;
  logic [7:0]  tx_sr_q;
  logic        addr_ok_q;
  logic        rd_q;
  logic        sda_oe_q;
  logic        code_tgl_q;
  logic        wr_tgl_q;
  logic [7:0]  code_lq;
  logic [7:0]  data_lo_q;
  gg_wr_s      wr_lq;

  // ==========================================================
  // Pin levels enter through two flops; idle lines rest high.
  gg_sync #(
    .W       (2),
    .RST_VAL (1'b1)
  ) u_pin_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({link_clock_line_i, link_data_line_i}),
    .q_o      (pin_s)
  );

  // Toggles from the link domain mark a new code and a new write.
  gg_sync #(
    .W       (2),
    .RST_VAL (1'b0)
  ) u_tgl_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({code_tgl_q, wr_tgl_q}),
    .q_o      (tgl_s)
  );

  // ==========================================================
  // Frame detection on the oversampled lines.
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire code_evt  = tgl_s[1] ^ tgl_seen_q[1];
  wire wr_evt    = tgl_s[0] ^ tgl_seen_q[0];

  // The link logic is held in reset between frames and for one cycle
  // at each start, so a repeated start always begins at the address.
  // Release happens while the clock line is high and stable, well
  // ahead of its next falling edge, so no link flop sees a race.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      in_frame_q <= 1'b0;
      link_run_q <= 1'b0;
      tgl_seen_q <= 2'h0;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      in_frame_q <= start_det | (in_frame_q & ~stop_det);
      link_run_q <= in_frame_q & ~start_det & ~stop_det;
      tgl_seen_q <= tgl_s;
    end
  end

  assign link_rst_n = arst_n_i & link_run_q;

  // ==========================================================
  // Write decode; codes not listed here are never stored.
  wire wr_cap  = wr_evt & (wr_lq.code == CODE_CAP_THR);
  wire wr_time = wr_evt & (wr_lq.code == CODE_TIME_THR);
  wire wr_mode = wr_evt & (wr_lq.code == CODE_MODE);
  wire lo_hit  = ~scl_s & ~sda_s;
  wire removed = lo_hit & (lo_cnt_q == REMOVE_CYC);

  // Capacity unit bit stays zero because only mAh is reported.
  assign mode_cfg = cfg_i.flag_word[CFG_QUIET_BIT] ?
                    (mode_q | (16'h0001 << MODE_ALL_OFF_BIT)) :
                    (mode_q & ~(16'h0001 << MODE_ALL_OFF_BIT));
  assign mode_upd = wr_mode    ? (wr_lq.data & MODE_WR_MASK) :
                    cfg_load_i ? mode_cfg : mode_q;
  assign mode_d   = removed ? (mode_upd & ~(16'h0001 << MODE_CHG_OFF_BIT))
                            : mode_upd;

  // Host writes win over a configuration load in the same cycle.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cap_thr_q  <= 16'h0000;
      time_thr_q <= RST_TIME_THR;
      mode_q     <= 16'h0000;
    end else begin
      cap_thr_q  <= wr_cap ? wr_lq.data :
                    cfg_load_i ? cfg_i.cap_thr : cap_thr_q;
      time_thr_q <= wr_time ? wr_lq.data :
                    cfg_load_i ? cfg_i.time_thr : time_thr_q;
      mode_q     <= mode_d;
    end
  end

  // ==========================================================
  // Pack removal: both lines low for longer than the limit. The
  // counter saturates so the clear fires once per removal.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_cnt_q <= 32'h0000_0000;
    end else if (!lo_hit) begin
      lo_cnt_q <= 32'h0000_0000;
    end else if (lo_cnt_q <= REMOVE_CYC) begin
      lo_cnt_q <= lo_cnt_q + 32'h0000_0001;
    end
  end

  assign pack_removed_o = lo_cnt_q > REMOVE_CYC;

  // ==========================================================
  // Live measurements and configuration copies with reset values.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meas_q <= MEAS_RST;
      cfg_q  <= '0;
    end else begin
      meas_q <= meas_i;
      cfg_q  <= cfg_load_i ? cfg_i : cfg_q;
    end
  end

  // Alarm bits follow the comparison both ways; other bits pass on.
  wire cap_alarm  = meas_q.capacity_left < cap_thr_q;
  wire time_alarm = meas_q.minutes_avg < time_thr_q;
  wire [15:0] status_d = (meas_q.status & ~STAT_OWN_MASK)
                       | ({15'h0000, cap_alarm} << STAT_CAP_BIT)
                       | ({15'h0000, time_alarm} << STAT_TIME_BIT);
  wire [15:0] temp_rd  = (meas_q.temperature > TEMP_MAX) ?
                         TEMP_MAX : meas_q.temperature;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= status_d;
    end
  end

  assign status_o = status_q;
  assign mode_o   = mode_q;

  // ==========================================================
  // Read selection. Reserved and unlisted codes answer a fixed word.
  always_comb begin
    rd_snap = '{blk: 1'b0, word: RSVD_READ};
    unique case (code_q)
      CODE_VENDOR:    rd_snap.word = RSVD_READ;
      CODE_CAP_THR:   rd_snap.word = cap_thr_q;
      CODE_TIME_THR:  rd_snap.word = time_thr_q;
      CODE_MODE:      rd_snap.word = mode_q;
      CODE_TEMP:      rd_snap.word = temp_rd;
      CODE_VOLT:      rd_snap.word = meas_q.voltage;
      CODE_CURR:      rd_snap.word = meas_q.current;
      CODE_AVG_CURR:  rd_snap.word = meas_q.avg_current;
      CODE_ERR:       rd_snap.word = meas_q.error_margin;
      CODE_PCT_FULL:  rd_snap.word = meas_q.pct_full;
      CODE_PCT_DSGN:  rd_snap.word = meas_q.pct_design;
      CODE_CAP_LEFT:  rd_snap.word = meas_q.capacity_left;
      CODE_FULL_CAP:  rd_snap.word = meas_q.full_cap;
      CODE_MIN_NOW:   rd_snap.word = meas_q.minutes_now;
      CODE_MIN_AVG:   rd_snap.word = meas_q.minutes_avg;
      CODE_CHG_CURR:  rd_snap.word = meas_q.chg_current;
      CODE_CHG_VOLT:  rd_snap.word = meas_q.chg_voltage;
      CODE_STATUS:    rd_snap.word = status_q;
      CODE_CYCLES:    rd_snap.word = meas_q.cycles;
      CODE_DSGN_CAP:  rd_snap.word = cfg_q.design_cap;
      CODE_DSGN_VOLT: rd_snap.word = cfg_q.design_volt;
      CODE_SPEC:      rd_snap.word = cfg_q.spec_rev;
      CODE_DATE:      rd_snap.word = cfg_q.build_date;
      CODE_SERIAL:    rd_snap.word = cfg_q.serial;
      CODE_MAKER_STR: rd_snap = '{blk: 1'b1, word: cfg_q.maker_str};
      CODE_PART_STR:  rd_snap = '{blk: 1'b1, word: cfg_q.part_str};
      CODE_CHEM_STR:  rd_snap = '{blk: 1'b1, word: cfg_q.chem_str};
      CODE_DATA_STR:  rd_snap = '{blk: 1'b1, word: cfg_q.maker_data};
      CODE_CFG_FLAGS: rd_snap.word = cfg_q.flag_word;
      CODE_EDV_FIRST: rd_snap.word = cfg_q.edv_first;
      CODE_EDV_FINAL: rd_snap.word = cfg_q.edv_final;
      default:        rd_snap.word = RSVD_READ;
    endcase
  end

  // The code is taken once its byte ends; the answer is frozen at the
  // next start so the link side reads a word that cannot move under it.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_q <= CODE_VENDOR;
      snap_q <= '{blk: 1'b0, word: RSVD_READ};
    end else begin
      code_q <= code_evt ? code_lq : code_q;
      snap_q <= start_det ? rd_snap : snap_q;
    end
  end

  // ==========================================================
  // Charger broadcast requests for the bus-master engine.
  wire bc_tick   = bc_cnt_q == BCAST_CYC - 1;
  wire chg_ok    = ~mode_q[MODE_CHG_OFF_BIT] & ~mode_q[MODE_ALL_OFF_BIT];
  wire alarm_any = |(status_q & STAT_ALARM_MASK);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bc_cnt_q <= 32'h0000_0000;
      bcast_q  <= '0;
    end else begin
      bc_cnt_q <= bc_tick ? 32'h0000_0000 : bc_cnt_q + 32'h0000_0001;
      bcast_q  <= '{chg_valid:    bc_tick & chg_ok,
                    alarm_valid:  bc_tick & alarm_any &
                                  ~mode_q[MODE_ALL_OFF_BIT],
                    chg_current:  meas_q.chg_current,
                    chg_voltage:  meas_q.chg_voltage,
                    alarm_status: status_q};
    end
  end

  assign bcast_o = bcast_q;

  // ==========================================================
  // Link domain byte engine, clocked by the host's clock line.
  wire       byte_done = bit_cnt_q == 4'h7;
  wire       ack_slot  = bit_cnt_q == 4'h8;
  wire [7:0] rx_byte   = {rx_sr_q[6:0], link_data_line_i};
  wire       tx_active = addr_ok_q & rd_q & (byte_idx_q != 3'h0);
  wire [2:0] next_idx  = byte_idx_q + 3'h1;

  // Word reads send low then high; block reads send a length first.
  wire [7:0] tx_word = (next_idx == 3'h1) ? snap_q.word[7:0] :
                       (next_idx == 3'h2) ? snap_q.word[15:8] : TX_PAD;
  wire [7:0] tx_blk  = (next_idx == 3'h1) ? BLOCK_LEN :
                       (next_idx == 3'h2) ? snap_q.word[7:0] :
                       (next_idx == 3'h3) ? snap_q.word[15:8] : TX_PAD;
  wire [7:0] tx_next = snap_q.blk ? tx_blk : tx_word;

  always_ff @(posedge link_clock_line_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= 3'h0;
      rx_sr_q    <= 8'h00;
      tx_sr_q    <= TX_PAD;
      addr_ok_q  <= 1'b0;
      rd_q       <= 1'b0;
    end else if (ack_slot) begin
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= (byte_idx_q == 3'h7) ? byte_idx_q : next_idx;
      tx_sr_q    <= tx_next;
    end else begin
      bit_cnt_q  <= bit_cnt_q + 4'h1;
      rx_sr_q    <= rx_byte;
      tx_sr_q    <= {tx_sr_q[6:0], 1'b1};
      if (byte_done && byte_idx_q == 3'h0) begin
        addr_ok_q <= rx_byte[7:1] == DEV_ADDR;
        rd_q      <= rx_byte[0];
      end
    end
  end

  // Code and write words live outside the frame reset so that a
  // repeated start keeps them; the toggles announce each new value.
  wire rx_take = byte_done & addr_ok_q & ~rd_q;
  always_ff @(posedge link_clock_line_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_tgl_q <= 1'b0;
      wr_tgl_q   <= 1'b0;
      code_lq    <= CODE_VENDOR;
      data_lo_q  <= 8'h00;
      wr_lq      <= '0;
    end else if (rx_take && byte_idx_q == 3'h1) begin
      code_lq    <= rx_byte;
      code_tgl_q <= ~code_tgl_q;
    end else if (rx_take && byte_idx_q == 3'h2) begin
      data_lo_q  <= rx_byte;
    end else if (rx_take && byte_idx_q == 3'h3) begin
      wr_lq      <= '{code: code_lq, data: {rx_byte, data_lo_q}};
      wr_tgl_q   <= ~wr_tgl_q;
    end
  end

  // Data changes only while the clock line is low: acknowledge each
  // received byte of our own frame, otherwise shift out read bytes.
  wire drive_low = (ack_slot & addr_ok_q & ~tx_active) |
                   (tx_active & ~ack_slot & ~tx_sr_q[7]);

  always_ff @(negedge link_clock_line_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= drive_low;
    end
  end

  // Open drain: only ever pull low, the host supplies the pull-up.
  assign link_data_line_o    = 1'b0;
  assign link_data_line_oe_o = sda_oe_q;

endmodule : gg_cmd_port
`default_nettype wire

// ===== verif/gg_cmd_port_props.sv
// Port checker for the gas-gauge command port.
`timescale 1ns/1ps
`default_nettype none
module gg_cmd_port_props #(
  parameter int unsigned REMOVE_CYC = 200
) (
  input wire logic              clk_i,
  input wire logic              arst_n_i,
  input wire logic              link_clock_line_i,
  input wire logic              link_data_line_i,
  input wire gg_pkg::gg_meas_s  meas_i,
  input wire gg_pkg::gg_cfg_s   cfg_i,
  input wire logic              cfg_load_i,
  input wire gg_pkg::gg_bcast_s bcast_o,
  input wire logic [15:0]       mode_o,
  input wire logic [15:0]       status_o,
  input wire logic              pack_removed_o
);
  import gg_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic [1:0]  up_q;
  logic [31:0] low_q;
  wire logic   low_w = !link_clock_line_i && !link_data_line_i;
  // Settling count keeps past values from before reset out of the status check.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      up_q  <= 2'h0;
      low_q <= 32'h0;
    end else begin
      up_q  <= up_q + {1'b0, up_q != 2'h3};
      low_q <= low_w ? low_q + 32'h1 : 32'h0;
    end
  end
  // ====================
  // Assertions.
  mode_unit_a: assert property (!mode_o[15])
    else $error("mode word bit 15 set");
  stat_pass_a: assert property (up_q == 2'h3 |->
    (status_o & ~STAT_OWN_MASK) == ($past(meas_i.status, 2) & ~STAT_OWN_MASK))
    else $error("status bits differ from measured status");
  chg_mute_a: assert property (bcast_o.chg_valid |->
    !$past(mode_o[14]) && !$past(mode_o[13]))
    else $error("charge words sent while muted");
  alarm_mute_a: assert property (bcast_o.alarm_valid |->
    !$past(mode_o[13]) && ($past(status_o) & STAT_ALARM_MASK) != 16'h0)
    else $error("alarm sent while muted or idle");
  bc_gap_a: assert property ($rose(bcast_o.chg_valid) |=>
    !bcast_o.chg_valid [*8]) else $error("broadcasts too close");
  rem_time_a: assert property ($rose(pack_removed_o) |->
    low_q > REMOVE_CYC) else $error("removal flagged early");
  rem_clear_a: assert property (pack_removed_o |=> !mode_o[14])
    else $error("mode bit 14 kept after removal");
  rem_exit_a: assert property (pack_removed_o && !low_w |->
    ##[1:4] !pack_removed_o) else $error("removal flag stuck");
  cfg_quiet_a: assert property (cfg_load_i |=>
    mode_o[13] == $past(cfg_i.flag_word[CFG_QUIET_BIT]))
    else $error("mode bit 13 not loaded");
  cover property ($rose(pack_removed_o));
  cover property (bcast_o.alarm_valid);
  cover property (cfg_load_i ##1 mode_o[13]);
endmodule : gg_cmd_port_props
bind gg_cmd_port gg_cmd_port_props #(.REMOVE_CYC(REMOVE_CYC)) u_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .link_clock_line_i(link_clock_line_i),
  .link_data_line_i(link_data_line_i), .meas_i(meas_i), .cfg_i(cfg_i),
  .cfg_load_i(cfg_load_i), .bcast_o(bcast_o), .mode_o(mode_o),
  .status_o(status_o), .pack_removed_o(pack_removed_o));
`default_nettype wire

// ===== verif/gg_host_model.sv
// Host master model that bit-bangs two-wire frames.
`timescale 1ns/1ps
`default_nettype none
module gg_host_model (
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // Half period of a 15 ns link clock.
  localparam realtime H = 7.5;
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  // Long holds cover the repeated-start gap and frame reset release.
  task automatic start();
    #2 sda_oe_o = 1'b0;
    #(H) scl_o = 1'b1;
    #(120) sda_oe_o = 1'b1;
    #(30) scl_o = 1'b0;
  endtask : start
  task automatic stop();
    #2 sda_oe_o = 1'b1;
    #(H) scl_o = 1'b1;
    #(H) sda_oe_o = 1'b0;
    #(H);
  endtask : stop
  // Eight bits MSB first, then the acknowledge slot; ones release the line.
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    logic [8:0] s;
    logic [8:0] r;
    s = {d, a};
    for (int i = 8; i >= 0; i--) begin
      #2 sda_oe_o = !s[i];
      #(H - 2) scl_o = 1'b1;
      r[i] = sda_i;
      #(H) scl_o = 1'b0;
    end
    q = r[8:1];
    k = r[0];
  endtask : xfer
  // Both lines grounded, as when the pack leaves the system.
  task automatic gnd(input logic on);
    scl_o = !on;
    #(H) sda_oe_o = on;
    #(H);
  endtask : gnd
endmodule : gg_host_model
`default_nettype wire

// ===== verif/gg_cmd_port_tb_top.sv
// Self-checking bench for the gas-gauge command port.
`timescale 1ns/1ps
`default_nettype none
module gg_cmd_port_tb_top;
  import gg_pkg::*;
  localparam int unsigned RC = 200;
  localparam logic [7:0]  AW = {DEV_ADDR_DEFAULT, 1'b0};
  logic        clk_i, arst_n_i, cfg_load_i, scl, h_oe, d_oe, rem, k, ak;
  logic [15:0] mode_o, status_o, rd_q;
  logic [7:0]  q;
  gg_meas_s    meas_i;
  gg_cfg_s     cfg_i;
  gg_bcast_s   bcast_o;
  int          bad_count, n_tests, cyc;
  // Pulled-up data line: whichever party pulls low wins.
  wire logic   sda = !(h_oe || d_oe);
  gg_cmd_port #(.REMOVE_CYC(RC), .BCAST_CYC(50)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .link_clock_line_i(scl),
    .link_data_line_i(sda), .link_data_line_o(), .link_data_line_oe_o(d_oe),
    .meas_i(meas_i), .cfg_i(cfg_i), .cfg_load_i(cfg_load_i),
    .bcast_o(bcast_o), .mode_o(mode_o), .status_o(status_o),
    .pack_removed_o(rem));
  gg_host_model h (.scl_o(scl), .sda_oe_o(h_oe), .sda_i(sda));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ====================
  // Shared tasks.
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : w
  task automatic wr(input logic [7:0] a, c, input logic [15:0] d);
    h.start();
    h.xfer(a, 1'b1, q, ak);
    h.xfer(c, 1'b1, q, k);
    h.xfer(d[7:0], 1'b1, q, k);
    h.xfer(d[15:8], 1'b1, q, k);
    h.stop();
  endtask : wr
  // Block reads carry a length byte ahead of the word.
  task automatic rd(input logic [7:0] c, input logic blk);
    logic [7:0] lo;
    h.start();
    h.xfer(AW, 1'b1, q, k);
    h.xfer(c, 1'b1, q, k);
    h.start();
    h.xfer(AW | 8'h01, 1'b1, q, k);
    if (blk) begin
      h.xfer(8'hff, 1'b0, q, k);
      chk("block length", {8'h0, q}, {8'h0, BLOCK_LEN});
    end
    h.xfer(8'hff, 1'b0, lo, k);
    h.xfer(8'hff, 1'b1, q, k);
    h.stop();
    rd_q = {q, lo};
  endtask : rd
  task automatic rc(input logic [7:0] c, input logic [15:0] e);
    rd(c, 1'b0);
    chk($sformatf("code %h", c), rd_q, e);
  endtask : rc
  task automatic bc(input logic [1:0] e);
    logic [1:0] s;
    s = 2'b00;
    repeat (120) begin
      @(posedge clk_i);
      #1 s = s | {bcast_o.chg_valid, bcast_o.alarm_valid};
    end
    chk("broadcasts", {14'h0, s}, {14'h0, e});
  endtask : bc
  // ====================
  // Scenarios.
  task automatic t_cfg();
    rc(CODE_TIME_THR, RST_TIME_THR);
    rc(CODE_ERR, RST_ERR_MARGIN);
    chk("mode", mode_o, 16'h0);
    w(1);
    cfg_i = '{flag_word: 16'h0800, time_thr: 16'h0077, maker_str: 16'hbeef,
              default: 16'h0};
    cfg_load_i = 1'b1;
    w(1);
    cfg_load_i = 1'b0;
    chk("quiet bit", mode_o & 16'h2000, 16'h2000);
    rc(CODE_TIME_THR, 16'h0077);
    rd(CODE_MAKER_STR, 1'b1);
    chk("block word", rd_q, 16'hbeef);
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_thr();
    wr(AW, CODE_CAP_THR, 16'h1234);
    chk("address ack", {15'h0, ak}, 16'h0);
    rc(CODE_CAP_THR, 16'h1234);
    w(1);
    meas_i.status = 16'h0020;
    meas_i.capacity_left = 16'h1233;
    meas_i.minutes_avg = 16'h0006;
    w(4);
    chk("capacity alarm", status_o & 16'h0200, 16'h0200);
    meas_i.capacity_left = 16'h1234;
    wr(AW, CODE_TIME_THR, 16'h0006);
    w(4);
    chk("alarms clear", status_o, 16'h0020);
    wr(AW, CODE_TIME_THR, 16'h0007);
    w(4);
    chk("time alarm", status_o, 16'h0120);
    $display("t_thr done");
  endtask : t_thr
  task automatic t_mode();
    wr(AW, CODE_MODE, 16'hffff);
    rc(CODE_MODE, 16'h7fff);
    wr(AW, CODE_MODE, 16'h2000);
    bc(2'b00);
    wr(AW, CODE_MODE, 16'h4000);
    bc(2'b01);
    wr(AW, CODE_MODE, 16'h0000);
    bc(2'b11);
    $display("t_mode done");
  endtask : t_mode
  task automatic t_ro();
    meas_i.temperature = 16'h2000;
    wr(AW, CODE_TEMP, 16'h5555);
    rc(CODE_TEMP, TEMP_MAX);
    wr(AW, CODE_VENDOR, 16'h1111);
    rc(8'h13, RSVD_READ);
    wr(8'h20, CODE_CAP_THR, 16'h0bad);
    chk("foreign ack", {15'h0, ak}, 16'h1);
    rc(CODE_CAP_THR, 16'h1234);
    $display("t_ro done");
  endtask : t_ro
  task automatic t_rem();
    wr(AW, CODE_MODE, 16'h4000);
    h.gnd(1'b1);
    w(RC + 20);
    chk("removed", {15'h0, rem}, 16'h1);
    chk("mode after removal", mode_o, 16'h0000);
    h.gnd(1'b0);
    w(10);
    chk("reinserted", {15'h0, rem}, 16'h0);
    $display("t_rem done");
  endtask : t_rem
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Main sequence after a ten-cycle reset.
  initial begin
    arst_n_i = 1'b0;
    cfg_load_i = 1'b0;
    meas_i = MEAS_RST;
    cfg_i = '0;
    w(10);
    arst_n_i = 1'b1;
    w(5);
    t_cfg();
    t_thr();
    t_mode();
    t_ro();
    t_rem();
    test_done();
  end
  // Hang guard well above the expected run length.
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
endmodule : gg_cmd_port_tb_top
`default_nettype wire
